// ---- rtl/tdm_switch_matrix_control.sv ----
`timescale 1ns/1ps
// How it works
// [R1] matched when both match inputs equal their straps
// [R2] with chip selects low, write bus, opcode and control latch on write rise
// [R3] readback driven only while read low, selected and matched
// [R4] read rise captures data select and match to steer sequence
// [R5] reset held at least one clock; init lasts exactly one frame
// [R6] init sets registers to ones, store disconnected, bus and outputs float
// [R7] invalid opcode holds attention low until valid one loaded
// [R8] instruction 5 finding active channel pulses attention two cycles
// [R9] status loaded with slot 0 message count pulses attention two cycles
// [R10] serial bit rate is master clock divided by two
// [R11] frame sync low resynchronises the time base counters
// [R12] each slot, input bytes written to speech store by line and slot
// [R13] connection entry bit 8 selects constant when high, speech data when low
// [R14] controller writes data bytes then the opcode
// [R15] invalid opcode not executed, attention low, registers kept
// [R16] unmatched type 2, 4, 6 ignored, attention untouched
// [R17] unmatched type 1 or 3 performed as disconnection
// [R18] matched executes as received; type 5 always executes
// [R19] two validate cycles, final step updates both readbacks
// [R20] instructions arriving during init or extraction wait for it to end; the engine holds them only for init
// [R21] type 6 lower priority; needs status read first
// [R22] nonzero mask stored; each frame copy, discount label 01, start if nonzero
// [R23] data select low means data byte, high means opcode
// [R24] read select low gives memory readback, high status readback
// [R25] reads return 8 bits, writes keep low 5 bits
// [R26] opcodes outside the six codes are invalid
// [R27] outputs driven from connection store, output time base ahead
module tdm_switch_matrix_control (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire tsw_pkg::cpu_in_t    cpu_in,
	input  wire logic                match_strap_1,
	input  wire logic                match_strap_2,
	input  wire logic                sync_n,
	input  wire logic [7:0]          serial_input_line,
	output logic      [7:0]          serial_output_line,
	output logic      [7:0]          serial_output_oe_n,
	output logic      [7:0]          data_out,
	output logic                     data_oe_n,
	output logic                     attention_n
);
	typedef enum logic [4:0] {
		ST_INIT = 5'h01, ST_IDLE = 5'h02, ST_VAL = 5'h04, ST_EXEC = 5'h08, ST_DONE = 5'h10
	} state_t;

	tsw_pkg::cpu_in_t sync_a_r, sync_b_r, p_r;
	logic [2:0] sy_r;
	logic [7:0] si1_r, si2_r;
	always_ff @(posedge clk) begin
		sync_a_r <= cpu_in;
		sync_b_r <= sync_a_r;
		p_r      <= sync_b_r;
		sy_r     <= {sy_r[1:0], sync_n};
		si1_r <= serial_input_line;
		si2_r <= si1_r;
	end

	function automatic logic sel_ok(input tsw_pkg::cpu_in_t c);
		return !c.chip_select_first_n && !c.chip_select_second_n;
	endfunction
	// [R1] match decode
	function automatic logic is_match(input tsw_pkg::cpu_in_t c);
		return (c.m1 == match_strap_1) && (c.m2 == match_strap_2);
	endfunction
	// [R26] opcode check
	function automatic logic op_valid(input logic [3:0] op);
		return op inside {tsw_pkg::OP_CONNECT, tsw_pkg::OP_DISC, tsw_pkg::OP_INSERT,
			tsw_pkg::OP_SAMPLE, tsw_pkg::OP_CTRLWORD, tsw_pkg::OP_MASK};
	endfunction

	wire wr_rise = sync_b_r.wr_n && !p_r.wr_n && sel_ok(p_r);
	wire rd_rise = sync_b_r.rd_n && !p_r.rd_n && sel_ok(p_r);

	// time base
	logic [8:0] tb_r, tb_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [8:0] cs_mem [256];
	logic [7:0] sp_mem [256];
	logic [7:0] ser_r, ser_nxt;
	// [R10] bit clock from halving master
	wire bit_edge = tb_r[0];
	wire slot_end = (tb_r[3:0] == 4'hF);
	wire [4:0] in_slot = tb_r[8:4];
	wire [4:0] out_slot = 5'(in_slot + 5'(tsw_pkg::OUT_ADVANCE));
	always_comb begin
		tb_nxt = 9'(tb_r + 9'h001);
		// [R11] sync falling edge realigns; only the settled stages are read
		if (sy_r[2] && !sy_r[1])
			tb_nxt = 9'h000;
		sh_nxt = sh_r;
		if (bit_edge) begin
			for (int l = 0; l < tsw_pkg::NUM_LINES; l++) begin
				sh_nxt[l] = si2_r[l];
			end
		end
	end

	logic [7:0] in_byte_r [8];
	genvar g;
	generate
		for (g = 0; g < tsw_pkg::NUM_LINES; g++) begin : g_line
			logic [7:0] cap_nxt;
			always_comb begin
				cap_nxt = in_byte_r[g];
				if (bit_edge)
					cap_nxt = {in_byte_r[g][6:0], sh_r[g]};
			end
			always_ff @(posedge clk) begin
				in_byte_r[g] <= cap_nxt;
			end
		end
	endgenerate

	// command engine
	state_t st_r, st_nxt;
	logic [4:0] stk_r [4], stk_nxt [4];
	logic [1:0] cnt_r, cnt_nxt;
	logic [3:0] op_r, op_nxt;
	logic       mt_r, mt_nxt, pend_r, pend_nxt, err_r, err_nxt;
	logic [3:0] ex_r, ex_nxt;
	logic [7:0] mem_rb_r, mem_rb_nxt, st_rb_r, st_rb_nxt;
	logic [7:0] exp_r, exp_nxt, bg_r, bg_nxt;
	logic       en6_r, en6_nxt, rdsel_r, rdsel_nxt, rdm_r, rdm_nxt;
	logic [1:0] pulse_r, pulse_nxt;
	logic [8:0] init_r, init_nxt;
	logic       cs_we, sp_we;
	logic [7:0] cs_wa;
	logic [8:0] cs_wd;

	wire four = (op_r == tsw_pkg::OP_CONNECT) || (op_r == tsw_pkg::OP_INSERT);
	wire [7:0] oaddr = four ? {stk_r[2][2:0], stk_r[3]} : {stk_r[0][2:0], stk_r[1]};
	wire [8:0] centry = cs_mem[oaddr];

	function automatic logic [3:0] popcnt(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = 4'(n + 4'(v[i]));
		return n;
	endfunction

	always_comb begin
		st_nxt = st_r;
		stk_nxt = stk_r;
		cnt_nxt = cnt_r;
		op_nxt = op_r;
		mt_nxt = mt_r;
		pend_nxt = pend_r;
		err_nxt = err_r;
		ex_nxt = ex_r;
		mem_rb_nxt = mem_rb_r;
		st_rb_nxt = st_rb_r;
		exp_nxt = exp_r;
		bg_nxt = bg_r;
		en6_nxt = en6_r;
		rdsel_nxt = rdsel_r;
		rdm_nxt = rdm_r;
		pulse_nxt = (pulse_r != 2'h0) ? 2'(pulse_r - 2'h1) : 2'h0;
		init_nxt = (init_r != 9'h000) ? 9'(init_r - 9'h001) : 9'h000;
		cs_we = 1'b0;
		cs_wa = oaddr;
		cs_wd = tsw_pkg::CS_DISC;
		// [R2] [R23] [R25] write capture
		if (wr_rise) begin
			if (!p_r.cmd_data_sel) begin
				stk_nxt[cnt_r] = p_r.data;
				cnt_nxt = 2'(cnt_r + 2'h1);
			end else if (op_valid(p_r.data[3:0])) begin
				op_nxt = p_r.data[3:0];
				mt_nxt = is_match(p_r);
				pend_nxt = 1'b1;
				cnt_nxt = 2'h0;
				// [R7] valid clears
				err_nxt = 1'b0;
			end else begin
				// [R15] reject, keep state
				err_nxt = 1'b1;
				cnt_nxt = 2'h0;
			end
		end
		// [R4] [R21] read rise steering
		if (rd_rise) begin
			rdsel_nxt = p_r.cmd_data_sel;
			rdm_nxt = is_match(p_r);
			if (p_r.cmd_data_sel && is_match(p_r))
				en6_nxt = 1'b1;
		end
		// [R22] per frame copy and discount
		if (tb_r == 9'(tsw_pkg::BITS_PER_SLOT * tsw_pkg::CLK_PER_BIT) && bg_r != 8'h00) begin
			for (int l = 0; l < 8; l++)
				exp_nxt[l] = bg_r[l] && (sp_mem[{3'(l), 5'h00}][7:6] != tsw_pkg::LABEL_SKIP);
			if (exp_nxt != 8'h00) begin
				st_rb_nxt = {3'(popcnt(exp_nxt)), 1'b1, tsw_pkg::OP_MASK};
				// [R9] count loaded
				pulse_nxt = 2'(tsw_pkg::ATTN_PULSE);
			end
		end
		case (st_r)
			// [R5] [R6] [R20] one frame init
			ST_INIT: if (init_r == 9'h000) st_nxt = ST_IDLE;
			ST_IDLE: if (pend_r && (op_r != tsw_pkg::OP_MASK || en6_r)) begin
				st_nxt = ST_VAL;
				ex_nxt = 4'(tsw_pkg::VALIDATE_CYC);
			end
			// [R19] validation span
			ST_VAL: if (ex_r == 4'h1) st_nxt = ST_EXEC;
				else ex_nxt = 4'(ex_r - 4'h1);
			ST_EXEC: begin
				// a valid opcode landing now must stay pending
				pend_nxt = wr_rise && p_r.cmd_data_sel && op_valid(p_r.data[3:0]);
				st_nxt = ST_DONE;
				// [R16] [R17] [R18] match handling
				if (mt_r || op_r == tsw_pkg::OP_CTRLWORD) begin
					case (op_r)
						tsw_pkg::OP_CONNECT: begin
							cs_we = 1'b1;
							cs_wd = {1'b0, stk_r[0][2:0], stk_r[1]};
						end
						tsw_pkg::OP_DISC: cs_we = 1'b1;
						// [R13] constant source
						tsw_pkg::OP_INSERT: begin
							cs_we = 1'b1;
							cs_wd = {1'b1, stk_r[0][2:0], stk_r[1]};
						end
						tsw_pkg::OP_MASK: begin
							bg_nxt = {stk_r[0][2:0], stk_r[1]};
							exp_nxt = bg_nxt;
							en6_nxt = 1'b0;
						end
						default: ;
					endcase
				end else if (four) begin
					cs_we = 1'b1;
				end
			end
			ST_DONE: begin
				st_nxt = ST_IDLE;
				mem_rb_nxt = centry[8] || op_r != tsw_pkg::OP_SAMPLE ?
					centry[7:0] : sp_mem[centry[7:0]];
				st_rb_nxt = {oaddr[7:5], centry[8], op_r};
				if (op_r == tsw_pkg::OP_MASK)
					st_rb_nxt = {3'(popcnt(bg_r)), bg_r != 8'h00, op_r};
				// [R8] active channel found
				if (op_r == tsw_pkg::OP_CTRLWORD && centry != tsw_pkg::CS_DISC)
					pulse_nxt = 2'(tsw_pkg::ATTN_PULSE);
			end
			default: st_nxt = ST_INIT;
		endcase
		if (!rst_n) begin
			st_nxt = ST_INIT;
			init_nxt = 9'(tsw_pkg::FRAME_CLKS - 1);
			mem_rb_nxt = tsw_pkg::REG_ONES;
			st_rb_nxt = tsw_pkg::REG_ONES;
			pend_nxt = 1'b0;
			err_nxt = 1'b0;
			en6_nxt = 1'b0;
			bg_nxt = 8'h00;
			exp_nxt = 8'h00;
			cnt_nxt = 2'h0;
			pulse_nxt = 2'h0;
			cs_we = 1'b1;
			cs_wa = tb_r[7:0];
		end else if (st_r == ST_INIT) begin
			cs_we = 1'b1;
			cs_wa = tb_r[7:0];
			cs_wd = tsw_pkg::CS_DISC;
		end
	end

	// [R12] speech store write each slot
	assign sp_we = slot_end && st_r != ST_INIT;
	// [R27] output from connection store
	always_comb begin
		for (int l = 0; l < 8; l++) begin
			logic [8:0] e;
			e = cs_mem[{3'(l), out_slot}];
			ser_nxt[l] = e[8] ? e[7 - tb_r[3:1]] : sp_mem[e[7:0]][7 - tb_r[3:1]];
			if (e == tsw_pkg::CS_DISC)
				ser_nxt[l] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		tb_r <= rst_n ? tb_nxt : 9'h000;
		sh_r <= sh_nxt;
		ser_r <= ser_nxt;
		st_r <= st_nxt;
		stk_r <= stk_nxt;
		cnt_r <= cnt_nxt;
		op_r <= op_nxt;
		mt_r <= mt_nxt;
		pend_r <= pend_nxt;
		err_r <= err_nxt;
		ex_r <= ex_nxt;
		mem_rb_r <= mem_rb_nxt;
		st_rb_r <= st_rb_nxt;
		exp_r <= exp_nxt;
		bg_r <= bg_nxt;
		en6_r <= en6_nxt;
		rdsel_r <= rdsel_nxt;
		rdm_r <= rdm_nxt;
		pulse_r <= pulse_nxt;
		init_r <= init_nxt;
		if (cs_we)
			cs_mem[cs_wa] <= cs_wd;
		if (sp_we)
			for (int l = 0; l < 8; l++)
				sp_mem[{3'(l), in_slot}] <= in_byte_r[l];
		// [R3] [R24] readback drive
		data_oe_n <= !(st_r != ST_INIT && rst_n && !sync_b_r.rd_n && sel_ok(sync_b_r)
			&& is_match(sync_b_r));
		data_out <= sync_b_r.cmd_data_sel ? st_rb_r : mem_rb_r;
		// [R6] outputs float in init; open drain low only
		serial_output_line <= 8'h00;
		serial_output_oe_n <= (st_r == ST_INIT || !rst_n) ? 8'hFF : ser_r;
		attention_n <= !rst_n ? 1'b1 : !(err_nxt || pulse_nxt != 2'h0);
	end

	// [R7] attention held during error
	a_err_attn: assert property (@(posedge clk) disable iff (!rst_n)
		err_r |-> !attention_n) else $error("attention not low on error"); // [R7]
	// [R5] init lasts one frame
	a_init_len: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_r == ST_IDLE) |-> $past(init_r) == 9'h000) else $error("init length"); // [R5]
	// [R3] bus floats when unselected
	a_bus_float: assert property (@(posedge clk) disable iff (!rst_n)
		sync_b_r.chip_select_first_n |=> data_oe_n) else $error("bus driven while unselected"); // [R3]
	// [R8] pulse length
	a_pulse_two: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse_r == 2'h2 && !err_r && !err_nxt) |-> ##1 pulse_r == 2'h1) else $error("pulse"); // [R8]
	// [R15] invalid keeps op
	a_bad_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_rise && p_r.cmd_data_sel && !op_valid(p_r.data[3:0])) |=> $stable(op_r))
		else $error("invalid opcode changed state"); // [R15]
	// [R19] validation two cycles
	a_val_two: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_r == ST_VAL) |-> ##2 st_r == ST_EXEC) else $error("validation span"); // [R19]
	// [R6] outputs float in init
	a_init_float: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == ST_INIT |=> serial_output_oe_n == 8'hFF) else $error("output not floating"); // [R6]
	// [R21] mask waits for status read
	a_mask_wait: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == ST_IDLE && op_r == tsw_pkg::OP_MASK && !en6_r) |=> st_r != ST_VAL)
		else $error("mask ran early"); // [R21]
endmodule

// ---- shared/tsw_pkg.sv ----
package tsw_pkg;
	localparam int NUM_LINES      = 8;
	localparam int NUM_SLOTS      = 32;
	localparam int BITS_PER_SLOT  = 8;
	localparam int CLK_PER_BIT    = 2;
	localparam real MCLK_MHZ      = 4.096;
	localparam real BIT_MBPS      = 2.048;
	localparam int  CLK_MHZ       = 200;
	localparam int FRAME_CLKS     = NUM_SLOTS * BITS_PER_SLOT * CLK_PER_BIT;
	localparam int OUT_ADVANCE    = 2;
	localparam int ATTN_PULSE     = 2;
	localparam int VALIDATE_CYC   = 2;
	localparam logic [3:0] OP_CONNECT  = 4'h1;
	localparam logic [3:0] OP_DISC     = 4'h2;
	localparam logic [3:0] OP_INSERT   = 4'h4;
	localparam logic [3:0] OP_SAMPLE   = 4'hB;
	localparam logic [3:0] OP_CTRLWORD = 4'h8;
	localparam logic [3:0] OP_MASK     = 4'hE;
	localparam logic [8:0] CS_DISC     = 9'h1FF;
	localparam logic [7:0] REG_ONES    = 8'hFF;
	localparam logic [1:0] LABEL_SKIP  = 2'h1;
	typedef struct packed {
		logic       chip_select_first_n;
		logic       chip_select_second_n;
		logic       wr_n;
		logic       rd_n;
		logic       cmd_data_sel;
		logic       m1;
		logic       m2;
		logic [4:0] data;
	} cpu_in_t;
endpackage

// ---- testbench/cpu_model.sv ----
`timescale 1ns/1ps
module cpu_model (
	input  wire logic        clk,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe_n,
	output tsw_pkg::cpu_in_t bus
);
	// idle: both selects and strobes high, data select low, unmatched
	initial bus = 12'hF2A;
	// data bytes carry select low, the opcode select high
	task automatic wr(input logic cd, input logic [1:0] m, input logic [4:0] d);
		@(posedge clk);
		bus <= '{1'b0, 1'b0, 1'b0, 1'b1, cd, m[1], m[0], d};
		repeat (4) @(posedge clk);
		bus.wr_n <= 1'b1;
		repeat (3) @(posedge clk);
		// released data shows the inverse so a stale byte never matches
		bus <= '{1'b1, 1'b1, 1'b1, 1'b1, cd, m[1], m[0], ~d};
		repeat (3) @(posedge clk);
	endtask
	// select and match held past the read rise
	task automatic rd(input logic cd, input logic [1:0] m, output logic [7:0] v,
		output logic oe_n);
		@(posedge clk);
		bus <= '{1'b0, 1'b0, 1'b1, 1'b0, cd, m[1], m[0], bus.data};
		repeat (6) @(posedge clk);
		v = data_out;
		oe_n = data_oe_n;
		bus.rd_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus.chip_select_first_n <= 1'b1;
		bus.chip_select_second_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic             clk;
	logic             rst_n;
	logic             sync_n;
	logic [7:0]       sin;
	tsw_pkg::cpu_in_t cpu;
	logic [7:0]       sout;
	logic [7:0]       soe_n;
	logic [7:0]       dout;
	logic             doe_n;
	logic             attn;
	int               err_count;
	int               check_count;
	int               cyc;
	int               fcnt;
	int               attn_cnt;
	int               low_cnt [8];
	localparam logic [1:0] MT = 2'b10;
	localparam logic [1:0] UM = 2'b01;
	localparam int         FR = tsw_pkg::FRAME_CLKS;
	localparam int         AP = tsw_pkg::ATTN_PULSE;

	tdm_switch_matrix_control tdm_switch_matrix_control_inst (
		.clk(clk), .rst_n(rst_n), .cpu_in(cpu), .match_strap_1(1'b1), .match_strap_2(1'b0),
		.sync_n(sync_n), .serial_input_line(sin), .serial_output_line(sout),
		.serial_output_oe_n(soe_n), .data_out(dout), .data_oe_n(doe_n),
		.attention_n(attn));
	cpu_model cpu_model_inst (.clk(clk), .data_out(dout), .data_oe_n(doe_n), .bus(cpu));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		fcnt <= (fcnt == FR - 1) ? 0 : fcnt + 1;
		sync_n <= (fcnt != 0);
	end
	// counting on the falling edge keeps clears at the rising edge race free
	always @(negedge clk) begin
		cyc++;
		if (attn === 1'b0) attn_cnt++;
		for (int i = 0; i < 8; i++) if (soe_n[i] === 1'b0) low_cnt[i]++;
		if (cyc == 20000) begin
			err_count++;
			$display("[FAIL] run_time expected done seen timeout");
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic ins(input logic [3:0] op, input logic [1:0] m, input logic [4:0] b0, b1,
		b2, b3, input bit four);
		cpu_model_inst.wr(1'b0, m, b0);
		cpu_model_inst.wr(1'b0, m, b1);
		if (four) begin
			cpu_model_inst.wr(1'b0, m, b2);
			cpu_model_inst.wr(1'b0, m, b3);
		end
		cpu_model_inst.wr(1'b1, m, {1'b0, op});
		repeat (20) @(posedge clk);
	endtask
	task automatic rb(input string nm, input logic [7:0] e1, e2);
		logic [7:0] v;
		logic       oe;
		cpu_model_inst.rd(1'b0, MT, v, oe);
		chk({nm, "_mem"}, e1, v);
		cpu_model_inst.rd(1'b1, MT, v, oe);
		chk({nm, "_status"}, e2, v);
		chk({nm, "_oe"}, 8'h00, {7'h00, oe});
	endtask
	task automatic lows(input int ln, input int e);
		repeat (FR) @(posedge clk);
		low_cnt[ln] = 0;
		repeat (FR) @(posedge clk);
		chk("serial_lows", e[7:0], low_cnt[ln][7:0]);
	endtask

	task automatic t_reset();
		chk("bus_oe", 8'h01, {7'h00, doe_n});
		chk("out_oe", 8'hFF, soe_n);
		chk("out_line", 8'h00, sout);
		chk("attn_rst", 8'h01, {7'h00, attn});
		rst_n <= 1'b1;
		repeat (40) @(posedge clk);
		attn_cnt = 0;
		ins(tsw_pkg::OP_CTRLWORD, MT, 5'h03, 5'h07, 5'h00, 5'h00, 0);
		repeat (600) @(posedge clk);
		rb("init", 8'hFF, 8'h78);
		chk("init_attn", 8'h00, attn_cnt[7:0]);
	endtask
	task automatic t_connect();
		ins(tsw_pkg::OP_CONNECT, MT, 5'h02, 5'h05, 5'h03, 5'h07, 1);
		rb("connect", 8'h45, 8'h61);
		lows(3, 8 * tsw_pkg::CLK_PER_BIT);
		attn_cnt = 0;
		ins(tsw_pkg::OP_CTRLWORD, MT, 5'h03, 5'h07, 5'h00, 5'h00, 0);
		chk("ctrl_pulse", AP[7:0], attn_cnt[7:0]);
		rb("ctrl", 8'h45, 8'h68);
	endtask
	task automatic t_insert();
		ins(tsw_pkg::OP_INSERT, MT, 5'h00, 5'h0F, 5'h05, 5'h09, 1);
		rb("insert", 8'h0F, 8'hB4);
		lows(5, 4 * tsw_pkg::CLK_PER_BIT);
	endtask
	task automatic t_unmatched();
		logic [7:0] v;
		logic       oe;
		attn_cnt = 0;
		ins(tsw_pkg::OP_DISC, UM, 5'h03, 5'h07, 5'h00, 5'h00, 0);
		ins(tsw_pkg::OP_CTRLWORD, UM, 5'h03, 5'h07, 5'h00, 5'h00, 0);
		chk("unm_pulse", AP[7:0], attn_cnt[7:0]);
		rb("unm_disc", 8'h45, 8'h68);
		ins(tsw_pkg::OP_INSERT, UM, 5'h00, 5'h0F, 5'h05, 5'h09, 1);
		ins(tsw_pkg::OP_SAMPLE, MT, 5'h05, 5'h09, 5'h00, 5'h00, 0);
		rb("sample", 8'hFF, 8'hBB);
		lows(5, 0);
		cpu_model_inst.rd(1'b1, UM, v, oe);
		chk("unm_read_oe", 8'h01, {7'h00, oe});
	endtask
	task automatic t_invalid();
		logic [3:0] bad [10] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hD, 4'hF};
		foreach (bad[i]) begin
			ins(bad[i], MT, 5'h01, 5'h01, 5'h00, 5'h00, 0);
			chk("attn_err", 8'h00, {7'h00, attn});
		end
		rb("invalid", 8'hFF, 8'hBB);
		ins(tsw_pkg::OP_DISC, MT, 5'h03, 5'h07, 5'h00, 5'h00, 0);
		chk("attn_clr", 8'h01, {7'h00, attn});
		rb("disc", 8'hFF, 8'h72);
		lows(3, 0);
	endtask
	task automatic t_extract();
		// mask enables input lines 0 and 2, neither carries label 01
		ins(tsw_pkg::OP_MASK, MT, 5'h00, 5'h05, 5'h00, 5'h00, 0);
		rb("mask", 8'hFF, 8'h5E);
		repeat (FR) @(posedge clk);
		attn_cnt = 0;
		repeat (2 * FR) @(posedge clk);
		chk("extract_pulse", 8'(2 * AP), attn_cnt[7:0]);
	endtask

	initial begin
		rst_n = 1'b0;
		sync_n = 1'b1;
		sin = 8'hFB;
		fcnt = 0;
		cyc = 0;
		err_count = 0;
		check_count = 0;
		attn_cnt = 0;
		repeat (8) @(posedge clk);
		t_reset();
		t_connect();
		t_insert();
		t_unmatched();
		t_invalid();
		t_extract();
		final_report();
	end
endmodule
